// ---- design/pgc_regs.sv ----
// Purpose: global configuration, global adc and per-port event registers behind spi
// Assumes: spi mode 0, sclk at most one quarter of clk, pins synchronised here
// Notes:   port event inputs are single-cycle pulses from the port state machines
`timescale 1ns/1ps

module pgc_regs
	import pgc_pkg::*;
#(
	parameter int SLEEP_T0_CYC = SLEEP_T0_US * CLK_MHZ,
	parameter int SLEEP_T1_CYC = SLEEP_T1_US * CLK_MHZ,
	parameter int SLEEP_T2_CYC = SLEEP_T2_US * CLK_MHZ
) (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        spi_sclk,
	input  wire logic                        spi_cs_n,
	input  wire logic                        spi_mosi,
	output logic                             spi_miso,
	output logic                             spi_miso_oe,
	input  wire logic [NUM_PORTS*EV_W-1:0]   port_event_pulse,
	input  wire logic                        nvm_refresh_done,
	input  wire logic                        adc_result_valid,
	input  wire logic [11:0]                 adc_result_data,
	output logic                             low_side_fault_overload_mask,
	output logic                             current_limit_timer_off,
	output logic                             sleep_fault_timer_en,
	output logic [19:0]                      sleep_fault_timer_limit,
	output logic                             nvm_refresh_req,
	output logic                             input_power_good_flag,
	output logic                             adc_enable,
	output logic                             adc_high_gain,
	output logic [2:0]                       adc_route,
	output logic [2:0]                       adc_route_port,
	output logic                             write_unlocked
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detect
	logic [1:0] sclk_sync;
	logic [1:0] cs_sync;
	logic [1:0] mosi_sync;
	logic       sclk_d;

	always_ff @(posedge clk) begin
		sclk_sync <= {sclk_sync[0], spi_sclk};
		cs_sync   <= {cs_sync[0], spi_cs_n};
		mosi_sync <= {mosi_sync[0], spi_mosi};
		sclk_d    <= sclk_sync[1];
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	assign sclk_rise = sclk_sync[1] & ~sclk_d & cs_active;
	assign sclk_fall = ~sclk_sync[1] & sclk_d & cs_active;
	assign cs_active = ~cs_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// spi frame engine
	logic [4:0]  bit_cnt;
	logic [23:0] rx_shift;
	logic [15:0] tx_shift;
	logic [6:0]  frame_addr;
	logic        frame_read;
	logic        wr_strobe;
	logic        rd_strobe;
	logic [15:0] wr_data;
	logic [15:0] rd_data;

	always_ff @(posedge clk) begin
		if (srst || !cs_active) begin
			bit_cnt <= 5'h00;
			rx_shift <= 24'h000000;
		end else if (sclk_rise && bit_cnt != SPI_FRAME_BITS) begin
			bit_cnt <= bit_cnt + 5'h01;
			rx_shift <= {rx_shift[22:0], mosi_sync[1]};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			frame_addr <= 7'h00;
			frame_read <= 1'b0;
		end else if (sclk_fall && bit_cnt == SPI_HDR_BITS) begin
			frame_addr <= rx_shift[7:1];
			frame_read <= rx_shift[0];
		end
	end

	// read data is fetched on the falling edge after the header
	logic hdr_fall;
	assign hdr_fall = sclk_fall && bit_cnt == SPI_HDR_BITS && rx_shift[0];
	assign rd_strobe = hdr_fall;
	assign wr_strobe = sclk_rise && bit_cnt == SPI_FRAME_BITS - 5'h01 && !frame_read;
	assign wr_data = {rx_shift[14:0], mosi_sync[1]};

	always_ff @(posedge clk) begin
		if (srst || !cs_active) begin
			tx_shift <= 16'h0000;
			spi_miso <= 1'b0;
		end else if (hdr_fall) begin
			spi_miso <= rd_data[15];
			tx_shift <= {rd_data[14:0], 1'b0};
		end else if (sclk_fall && bit_cnt > SPI_HDR_BITS && frame_read) begin
			spi_miso <= tx_shift[15];
			tx_shift <= {tx_shift[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= cs_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write protection
	logic wr_cmd;
	logic wr_ok;
	assign wr_cmd = wr_strobe && frame_addr == ADDR_GLOBAL_COMMAND;
	assign wr_ok = wr_strobe && write_unlocked;

	always_ff @(posedge clk) begin
		if (srst) begin
			write_unlocked <= 1'b0;
		end else if (wr_cmd && wr_data[7:0] == KEY_UNLOCK) begin
			write_unlocked <= 1'b1;
		end else if (wr_cmd && wr_data[7:0] == KEY_LOCK) begin
			write_unlocked <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// global configuration
	logic [1:0] sleep_sel;
	logic       wr_global_configuration;
	assign wr_global_configuration = wr_ok && frame_addr == ADDR_GLOBAL_CONFIGURATION;

	always_ff @(posedge clk) begin
		if (srst) begin
			low_side_fault_overload_mask <= 1'b0;
			current_limit_timer_off <= 1'b0;
			sleep_sel <= SLEEP_SEL_RESET;
			input_power_good_flag <= 1'b0;
		end else if (wr_global_configuration) begin
			low_side_fault_overload_mask <= wr_data[GLOBAL_CONFIGURATION_LOWFAULT_MASK_BIT];
			current_limit_timer_off <= wr_data[GLOBAL_CONFIGURATION_CURRENT_LIMIT_TIME_OFF_BIT];
			sleep_sel <= wr_data[GLOBAL_CONFIGURATION_SLEEP_SEL_LSB +: 2];
			input_power_good_flag <= wr_data[GLOBAL_CONFIGURATION_PGOOD_BIT];
		end
	end

	// refresh bit stays set until the memory copy reports done
	always_ff @(posedge clk) begin
		if (srst) begin
			nvm_refresh_req <= 1'b0;
		end else if (wr_global_configuration && wr_data[GLOBAL_CONFIGURATION_REFRESH_BIT]) begin
			nvm_refresh_req <= 1'b1;
		end else if (nvm_refresh_done) begin
			nvm_refresh_req <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sleep_fault_timer_en <= 1'b1;
			sleep_fault_timer_limit <= 20'(SLEEP_T2_CYC);
		end else begin
			sleep_fault_timer_en <= sleep_sel != SLEEP_SEL_OFF;
			unique case (sleep_sel)
				2'b00: sleep_fault_timer_limit <= 20'(SLEEP_T0_CYC);
				2'b01: sleep_fault_timer_limit <= 20'(SLEEP_T1_CYC);
				2'b10: sleep_fault_timer_limit <= 20'(SLEEP_T2_CYC);
				2'b11: sleep_fault_timer_limit <= 20'h00000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// global adc configuration
	pgc_adc_mode_e adc_mode;
	logic [4:0]    adc_sel;
	logic          wr_adccfg;
	assign wr_adccfg = wr_ok && frame_addr == ADDR_GLOBAL_ADC_CONFIGURATION;

	always_ff @(posedge clk) begin
		if (srst) begin
			adc_mode <= pgc_adc_mode_e'(ADC_MODE_RESET);
			adc_sel <= ADC_SEL_RESET;
		end else if (wr_adccfg) begin
			adc_mode <= pgc_adc_mode_e'(wr_data[ADC_MODE_LSB +: 2]);
			adc_sel <= wr_data[ADC_SEL_LSB +: 5];
		end else if (adc_mode == PGC_ADC_SINGLE && adc_result_valid) begin
			adc_mode <= PGC_ADC_OFF;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			adc_enable <= 1'b0;
			adc_high_gain <= 1'b0;
		end else begin
			adc_enable <= adc_mode != PGC_ADC_OFF;
			adc_high_gain <= adc_mode == PGC_ADC_CONT_H;
		end
	end

	logic [4:0] sel_ofs;
	assign sel_ofs = adc_sel - ADC_SEL_PORT_LO;

	always_ff @(posedge clk) begin
		if (srst) begin
			adc_route <= PGC_RT_GND;
			adc_route_port <= 3'h0;
		end else begin
			adc_route_port <= sel_ofs[3:1];
			if (adc_sel[4]) begin
				adc_route <= PGC_RT_REF;
			end else if (adc_sel == ADC_SEL_GND) begin
				adc_route <= PGC_RT_GND;
			end else if (adc_sel == ADC_SEL_VIN) begin
				adc_route <= PGC_RT_VIN;
			end else if (adc_sel == ADC_SEL_TEMP) begin
				adc_route <= PGC_RT_TEMP;
			end else if (adc_sel >= ADC_SEL_PORT_LO && adc_sel <= ADC_SEL_PORT_HI) begin
				adc_route <= adc_sel[0] ? PGC_RT_PRET : PGC_RT_POUT;
			end else begin
				adc_route <= PGC_RT_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// global adc result
	logic [11:0] adc_value;
	logic        adc_fresh;
	logic        adc_lost;
	logic        rd_adcdat;
	assign rd_adcdat = rd_strobe && rx_shift[7:1] == ADDR_GLOBAL_ADC_RESULT;

	always_ff @(posedge clk) begin
		if (srst) begin
			adc_value <= 12'h000;
		end else if (adc_result_valid) begin
			adc_value <= adc_result_data;
		end
	end

	// a store in the read cycle wins over the read clear
	always_ff @(posedge clk) begin
		if (srst) begin
			adc_fresh <= 1'b0;
			adc_lost <= 1'b0;
		end else if (adc_result_valid) begin
			adc_fresh <= 1'b1;
			adc_lost <= adc_lost | (adc_fresh & ~rd_adcdat);
		end else if (rd_adcdat) begin
			adc_fresh <= 1'b0;
			adc_lost <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-port event flags, bit order 9..0
	// valid sig, invalid sig, discharge, sleep ovl, powered ovl,
	// dropout, inrush, wake, ls forward, ls reverse
	logic [EV_W-1:0] port_ev [NUM_PORTS];

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			localparam logic [6:0] PADDR = 7'(ADDR_PORT_BASE + gp * ADDR_PORT_STRIDE + ADDR_PORT_EVENT_OFS);
			logic            wr_ev;
			logic [EV_W-1:0] clr;
			assign wr_ev = wr_ok && frame_addr == PADDR;
			assign clr = wr_ev ? wr_data[EV_W-1:0] : '0;
			always_ff @(posedge clk) begin
				if (srst) begin
					port_ev[gp] <= '0;
				end else begin
					port_ev[gp] <= (port_ev[gp] & ~clr) | port_event_pulse[gp*EV_W +: EV_W];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read mux, header address straight from the shifter
	logic [6:0] rd_addr;
	assign rd_addr = rx_shift[7:1];

	always_comb begin
		rd_data = 16'h0000;
		unique case (rd_addr)
			ADDR_GLOBAL_COMMAND: rd_data = 16'h0000;
			ADDR_GLOBAL_CONFIGURATION: begin
				rd_data[GLOBAL_CONFIGURATION_LOWFAULT_MASK_BIT] = low_side_fault_overload_mask;
				rd_data[GLOBAL_CONFIGURATION_CURRENT_LIMIT_TIME_OFF_BIT] = current_limit_timer_off;
				rd_data[GLOBAL_CONFIGURATION_SLEEP_SEL_LSB +: 2] = sleep_sel;
				rd_data[GLOBAL_CONFIGURATION_REFRESH_BIT] = nvm_refresh_req;
				rd_data[GLOBAL_CONFIGURATION_PGOOD_BIT] = input_power_good_flag;
			end
			ADDR_GLOBAL_ADC_CONFIGURATION: begin
				rd_data[ADC_MODE_LSB +: 2] = adc_mode;
				rd_data[ADC_SEL_LSB +: 5] = adc_sel;
			end
			ADDR_GLOBAL_ADC_RESULT: begin
				rd_data[11:0] = adc_value;
				rd_data[ADC_FRESH_BIT] = adc_fresh;
				rd_data[ADC_LOST_BIT] = adc_lost;
			end
			default: begin
				for (int p = 0; p < NUM_PORTS; p++) begin
					if (rd_addr == 7'(ADDR_PORT_BASE + p * ADDR_PORT_STRIDE + ADDR_PORT_EVENT_OFS)) begin
						rd_data[EV_W-1:0] = port_ev[p];
					end
				end
			end
		endcase
	end

endmodule

// ---- inc/pgc_pkg.sv ----
// Purpose: shared constants for the global config, adc and port event register block
// Assumes: 10 MHz core clock, 16-bit registers, 7-bit register addresses
// Notes:   register offsets, field positions, reset values and timer figures live here

package pgc_pkg;

	localparam int NUM_PORTS = 5;
	localparam int EV_W      = 10;
	localparam int CLK_MHZ   = 10;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [6:0] ADDR_GLOBAL_COMMAND            = 7'h08;
	localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION      = 7'h09;
	localparam logic [6:0] ADDR_GLOBAL_ADC_CONFIGURATION  = 7'h0A;
	localparam logic [6:0] ADDR_GLOBAL_ADC_RESULT         = 7'h0B;
	localparam logic [6:0] ADDR_PORT_BASE                 = 7'h10;
	localparam logic [6:0] ADDR_PORT_STRIDE               = 7'h10;
	localparam logic [3:0] ADDR_PORT_EVENT_OFS            = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// write protect keys
	localparam logic [7:0] KEY_UNLOCK = 8'h05;
	localparam logic [7:0] KEY_LOCK   = 8'hA0;

	////////////////////////////////////////////////////////////////////////////////
	// global configuration fields
	localparam int GLOBAL_CONFIGURATION_LOWFAULT_MASK_BIT = 5;
	localparam int GLOBAL_CONFIGURATION_CURRENT_LIMIT_TIME_OFF_BIT      = 4;
	localparam int GLOBAL_CONFIGURATION_SLEEP_SEL_LSB     = 2;
	localparam int GLOBAL_CONFIGURATION_REFRESH_BIT       = 1;
	localparam int GLOBAL_CONFIGURATION_PGOOD_BIT         = 0;
	localparam logic [1:0]  SLEEP_SEL_RESET = 2'h2;
	localparam logic [1:0]  SLEEP_SEL_OFF   = 2'h3;

	// sleep fault timer figures in microseconds
	localparam int SLEEP_T0_US = 15600;
	localparam int SLEEP_T1_US = 31200;
	localparam int SLEEP_T2_US = 62500;

	////////////////////////////////////////////////////////////////////////////////
	// adc configuration and result fields
	localparam int ADC_MODE_LSB  = 5;
	localparam int ADC_SEL_LSB   = 0;
	localparam int ADC_LOST_BIT  = 13;
	localparam int ADC_FRESH_BIT = 12;
	localparam logic [1:0] ADC_MODE_RESET = 2'h0;
	localparam logic [4:0] ADC_SEL_RESET  = 5'h00;

	typedef enum logic [1:0] {
		PGC_ADC_OFF    = 2'b00,
		PGC_ADC_SINGLE = 2'b01,
		PGC_ADC_CONT_L = 2'b10,
		PGC_ADC_CONT_H = 2'b11
	} pgc_adc_mode_e;

	typedef enum logic [2:0] {
		PGC_RT_GND  = 3'b000,
		PGC_RT_VIN  = 3'b001,
		PGC_RT_TEMP = 3'b010,
		PGC_RT_POUT = 3'b011,
		PGC_RT_PRET = 3'b100,
		PGC_RT_REF  = 3'b101,
		PGC_RT_NONE = 3'b110
	} pgc_route_e;

	localparam logic [4:0] ADC_SEL_GND      = 5'h00;
	localparam logic [4:0] ADC_SEL_VIN      = 5'h01;
	localparam logic [4:0] ADC_SEL_TEMP     = 5'h02;
	localparam logic [4:0] ADC_SEL_PORT_LO  = 5'h04;
	localparam logic [4:0] ADC_SEL_PORT_HI  = 5'h0D;

	////////////////////////////////////////////////////////////////////////////////
	// spi frame layout: 7-bit address, rw bit, 16 data bits
	localparam logic [4:0] SPI_HDR_BITS   = 5'h08;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

endpackage

// ---- verification/pgc_regs_chk.sv ----
// Purpose: port-level checks for the global config, adc configuration, miso enable and write lock outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to pgc_regs; only watches outputs against their causes
`timescale 1ns/1ps

module pgc_regs_chk
	import pgc_pkg::*;
#(
	parameter int SLEEP_T0_CYC = SLEEP_T0_US * CLK_MHZ,
	parameter int SLEEP_T1_CYC = SLEEP_T1_US * CLK_MHZ,
	parameter int SLEEP_T2_CYC = SLEEP_T2_US * CLK_MHZ
) (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        spi_cs_n,
	input wire logic        spi_miso_oe,
	input wire logic        nvm_refresh_done,
	input wire logic        low_side_fault_overload_mask,
	input wire logic        current_limit_timer_off,
	input wire logic        sleep_fault_timer_en,
	input wire logic [19:0] sleep_fault_timer_limit,
	input wire logic        nvm_refresh_req,
	input wire logic        input_power_good_flag,
	input wire logic        adc_enable,
	input wire logic        adc_high_gain,
	input wire logic [2:0]  adc_route,
	input wire logic [2:0]  adc_route_port,
	input wire logic        write_unlocked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////////////
	// sequences
	sequence s_idle;
		spi_cs_n [*4];
	endsequence
	sequence s_cfg_move;
		!$past(srst) && ($changed(low_side_fault_overload_mask) || $changed(input_power_good_flag) || $rose(nvm_refresh_req));
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// properties
	property p_cfg_locked;
		!write_unlocked |=> $stable(low_side_fault_overload_mask) && $stable(current_limit_timer_off)
			&& $stable(input_power_good_flag) && !$rose(nvm_refresh_req);
	endproperty
	property p_cfg_frame;
		s_cfg_move |-> !spi_cs_n;
	endproperty
	property p_limit;
		sleep_fault_timer_limit inside {SLEEP_T0_CYC, SLEEP_T1_CYC, SLEEP_T2_CYC, 0};
	endproperty
	property p_timer_en;
		sleep_fault_timer_en == (sleep_fault_timer_limit != 20'h0);
	endproperty
	property p_gain;
		adc_high_gain |-> adc_enable;
	endproperty
	property p_route;
		adc_route != 3'h7 && ($past(srst) || !$changed(adc_route) || (!spi_cs_n && write_unlocked));
	endproperty
	property p_miso_oe;
		!$past(srst) |-> spi_miso_oe == !$past(spi_cs_n, 3);
	endproperty
	property p_route_port;
		adc_route inside {3'h3, 3'h4} |-> adc_route_port < NUM_PORTS;
	endproperty
	property p_refresh_done;
		s_idle ##0 (nvm_refresh_req && nvm_refresh_done) |=> !nvm_refresh_req;
	endproperty
	property p_key_frame;
		!$past(srst) && $changed(write_unlocked) |-> !spi_cs_n;
	endproperty

	a_cfg_locked: assert property (p_cfg_locked) else $error("config moved while locked");
	a_cfg_frame: assert property (p_cfg_frame) else $error("config moved outside a frame");
	a_limit: assert property (p_limit) else $error("sleep timer limit not a listed value");
	a_timer_en: assert property (p_timer_en) else $error("sleep timer enable disagrees with limit");
	a_gain: assert property (p_gain) else $error("high gain without adc enable");
	a_route: assert property (p_route) else $error("illegal adc route");
	a_route_port: assert property (p_route_port) else $error("adc port out of range");
	a_refresh_done: assert property (p_refresh_done) else $error("refresh request not cleared");
	a_key_frame: assert property (p_key_frame) else $error("unlock state moved outside a frame");
	a_miso_oe: assert property (p_miso_oe) else $error("miso enable does not follow chip select");
endmodule

bind pgc_regs pgc_regs_chk #(
	.SLEEP_T0_CYC(SLEEP_T0_CYC),
	.SLEEP_T1_CYC(SLEEP_T1_CYC),
	.SLEEP_T2_CYC(SLEEP_T2_CYC)
) u_chk (
	.clk(clk), .srst(srst), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe), .nvm_refresh_done(nvm_refresh_done),
	.low_side_fault_overload_mask(low_side_fault_overload_mask), .current_limit_timer_off(current_limit_timer_off),
	.sleep_fault_timer_en(sleep_fault_timer_en), .sleep_fault_timer_limit(sleep_fault_timer_limit),
	.nvm_refresh_req(nvm_refresh_req), .input_power_good_flag(input_power_good_flag), .adc_enable(adc_enable),
	.adc_high_gain(adc_high_gain), .adc_route(adc_route), .adc_route_port(adc_route_port),
	.write_unlocked(write_unlocked)
);

// ---- verification/pgc_regs_bench.sv ----
// Purpose: self-checking bench for the global config, adc and port event registers
// Assumes: spi mode 0 at clk/6, short sleep timer counts 20/40/80
// Notes:   all register traffic goes through the spi frame tasks
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %0t got %h exp %h", $time, (g), (e)); end end

module pgc_regs_bench;
	import pgc_pkg::*;
	logic        clk = 0, srst = 1, sclk = 0, cs_n = 1, mosi = 0, nvm_done = 0, av = 0;
	logic [49:0] ev = '0;
	logic [11:0] ad = '0;
	logic        miso, moe, oe, lmask, discharge_time, sen, req, pg, aen, hg, unl;
	logic [19:0] lim;
	logic [2:0]  rt, rp;
	logic [15:0] rd;
	logic [6:0]  pa;
	logic [9:0]  pat;
	int          mismatches = 0, comparisons = 0;

	pgc_regs #(.SLEEP_T0_CYC(20), .SLEEP_T1_CYC(40), .SLEEP_T2_CYC(80)) u_dut (
		.clk(clk), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.spi_miso_oe(moe), .port_event_pulse(ev), .nvm_refresh_done(nvm_done), .adc_result_valid(av),
		.adc_result_data(ad), .low_side_fault_overload_mask(lmask), .current_limit_timer_off(discharge_time),
		.sleep_fault_timer_en(sen), .sleep_fault_timer_limit(lim), .nvm_refresh_req(req),
		.input_power_good_flag(pg), .adc_enable(aen), .adc_high_gain(hg), .adc_route(rt),
		.adc_route_port(rp), .write_unlocked(unl)
	);

	initial begin
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// tasks
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task xfer(input logic [6:0] a, input logic r, input logic [15:0] d);
		logic [23:0] f;
		f = {a, r, d};
		cs_n = 0;
		cyc(3);
		oe = moe;
		for (int i = 23; i >= 0; i--) begin
			mosi = f[i];
			sclk = 0;
			cyc(3);
			sclk = 1;
			cyc(3);
			if (i < 16) rd[i] = miso;
		end
		sclk = 0;
		cyc(3);
		cs_n = 1;
		cyc(6);
	endtask
	task wr(input logic [6:0] a, input logic [15:0] d);
		xfer(a, 1'b0, d);
	endtask
	task rdc(input logic [6:0] a, input logic [15:0] e);
		xfer(a, 1'b1, 16'h0000);
		`CHK({oe, rd}, {1'b1, e})
	endtask
	task adc(input logic [11:0] v);
		ad = v;
		av = 1;
		cyc(1);
		av = 0;
		cyc(1);
	endtask
	function automatic logic [2:0] rte(input int s);
		if (s >= 16) return 3'h5;
		if (s >= 4 && s <= 13) return 3'(3 + s[0]);
		if (s == 3 || s > 13) return 3'h6;
		return 3'(s);
	endfunction
	task end_of_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#(40000 * 100);
		mismatches++;
		end_of_test;
	end

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		cyc(4);
		srst = 0;
		cyc(4);
		`CHK({sen, lim, moe}, {1'b1, 20'd80, 1'b0})
		rdc(ADDR_GLOBAL_CONFIGURATION, 16'h0008);
		wr(ADDR_GLOBAL_CONFIGURATION, 16'h0031);
		rdc(ADDR_GLOBAL_CONFIGURATION, 16'h0008);
		wr(ADDR_GLOBAL_COMMAND, {8'h00, KEY_UNLOCK});
		`CHK(unl, 1'b1)
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_GLOBAL_CONFIGURATION, 16'h0031 | (16'(c) << 2));
			`CHK({lmask, discharge_time, pg}, 3'h7)
			`CHK(lim, c == 3 ? 20'd0 : 20'd20 << c)
			`CHK(sen, 1'(c != 3))
			rdc(ADDR_GLOBAL_CONFIGURATION, 16'h0031 | (16'(c) << 2));
		end
		wr(ADDR_GLOBAL_CONFIGURATION, 16'h0002);
		rdc(ADDR_GLOBAL_CONFIGURATION, 16'h0002);
		nvm_done = 1;
		cyc(1);
		nvm_done = 0;
		cyc(2);
		`CHK(req, 1'b0)
		for (int s = 0; s < 32; s++) begin
			wr(ADDR_GLOBAL_ADC_CONFIGURATION, 16'h0040 | 16'(s));
			`CHK(rt, rte(s))
			if (s >= 4 && s <= 13) `CHK(rp, 3'((s - 4) >> 1))
		end
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_GLOBAL_ADC_CONFIGURATION, 16'(m) << 5);
			`CHK({aen, hg}, {1'(m != 0), 1'(m == 3)})
		end
		wr(ADDR_GLOBAL_ADC_CONFIGURATION, 16'h0020);
		adc(12'hABC);
		cyc(2);
		`CHK(aen, 1'b0)
		rdc(ADDR_GLOBAL_ADC_CONFIGURATION, 16'h0000);
		rdc(ADDR_GLOBAL_ADC_RESULT, 16'h1ABC);
		adc(12'h123);
		adc(12'h456);
		rdc(ADDR_GLOBAL_ADC_RESULT, 16'h3456);
		rdc(ADDR_GLOBAL_ADC_RESULT, 16'h0456);
		for (int p = 0; p < NUM_PORTS; p++) begin
			pa = 7'(16 * (p + 1));
			pat = 10'h2B5 ^ 10'(p);
			ev[p*10 +: 10] = pat;
			cyc(1);
			ev = '0;
			wr(pa, 16'h0000);
			rdc(pa, 16'(pat));
			wr(pa, 16'h00F0);
			rdc(pa, 16'(pat & 10'h30F));
			wr(pa, 16'hFFFF);
			rdc(pa, 16'h0000);
		end
		rdc(7'h0C, 16'h0000);
		wr(ADDR_GLOBAL_COMMAND, {8'h00, KEY_LOCK});
		`CHK(unl, 1'b0)
		ev[0] = 1;
		cyc(1);
		ev = '0;
		wr(7'h10, 16'hFFFF);
		rdc(7'h10, 16'h0001);
		srst = 1;
		cyc(4);
		srst = 0;
		cyc(4);
		rdc(7'h10, 16'h0000);
		`CHK({sen, lim, unl}, {1'b1, 20'd80, 1'b0})
		end_of_test;
	end
endmodule
